// >>> core/acs_cfg.svh
// offsets, field positions, reset values and sizes for the converter select block
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// register indices as printed; byte address is four times the index
`define ACS_IDX_RES_LOW 8'h78
`define ACS_IDX_RES_HIGH 8'h79
`define ACS_IDX_SEL 8'h7C
`define ACS_IDX_CTRL 8'h70
`define ACS_IDX_IRQ_STAT 8'h71
`define ACS_IDX_IRQ_MASK 8'h72

`define ACS_ADDR_W 12
`define ACS_ADDR_RES_LOW 12'h1E0
`define ACS_ADDR_RES_HIGH 12'h1E4
`define ACS_ADDR_SEL 12'h1F0
`define ACS_ADDR_CTRL 12'h1C0
`define ACS_ADDR_IRQ_STAT 12'h1C4
`define ACS_ADDR_IRQ_MASK 12'h1C8

// select register fields
`define ACS_SEL_REF_HI 7
`define ACS_SEL_REF_LO 6
`define ACS_SEL_ALIGN 5
`define ACS_SEL_CODE_HI 4
`define ACS_SEL_CODE_LO 0
`define ACS_SEL_RESET 8'h00

// control and interrupt fields
`define ACS_CTRL_START 0
`define ACS_IRQ_DONE 0
`define ACS_IRQ_OVERRUN 1
`define ACS_IRQ_W 2
`define ACS_IRQ_RESET 2'h0

// result coding
`define ACS_RES_W 10
`define ACS_RAW_W 11
`define ACS_SE_MAX 10'h3FF
`define ACS_DIFF_POS_MAX 10'h1FF
`define ACS_DIFF_NEG_MIN 10'h200
`define ACS_RES_RESET 10'h000
`define ACS_CODE_SE_LAST 5'h07
`define ACS_CODE_BANDGAP 5'h1E
`define ACS_CODE_GROUND 5'h1F
`define ACS_NEG_INPUT_ONE 3'h1
`define ACS_NEG_INPUT_TWO 3'h2
`define ACS_NEG_INPUT_ZERO 3'h0

`endif

// >>> core/acs_chan_decode.sv
// channel and gain code decoder
`timescale 1ns/1ps
`include "acs_cfg.svh"

module acs_chan_decode (
  input wire logic [4:0] i_code,
  output logic o_diff,
  output logic [2:0] o_pos_input,
  output logic [2:0] o_neg_input,
  output acs_pkg::acs_gain_t o_gain,
  output logic o_bandgap,
  output logic o_ground
);
  import acs_pkg::*;

  always_comb begin
    o_diff = 1'b0;
    o_pos_input = i_code[2:0];
    o_neg_input = `ACS_NEG_INPUT_ZERO;
    o_gain = ACS_GAIN_1X;
    o_bandgap = 1'b0;
    o_ground = 1'b0;
    if (i_code <= `ACS_CODE_SE_LAST) begin
      o_diff = 1'b0; // R15
    end else if (i_code == `ACS_CODE_BANDGAP) begin
      o_bandgap = 1'b1; // R15
    end else if (i_code == `ACS_CODE_GROUND) begin
      o_ground = 1'b1; // R15
    end else if (i_code[4:3] == 2'h1) begin
      // pairs on 0/1 and 2/3, bit 1 picks the high gain
      o_diff = 1'b1; // R16
      o_neg_input = i_code[2] ? `ACS_NEG_INPUT_TWO : `ACS_NEG_INPUT_ZERO;
      o_pos_input = {1'b0, i_code[2], i_code[0]};
      o_gain = i_code[1] ? ACS_GAIN_200X : ACS_GAIN_10X;
    end else if (i_code[4:3] == 2'h2) begin
      o_diff = 1'b1; // R16
      o_neg_input = `ACS_NEG_INPUT_ONE;
    end else begin
      o_diff = 1'b1; // R16
      o_neg_input = `ACS_NEG_INPUT_TWO;
    end
  end

endmodule : acs_chan_decode

// >>> core/acs_pkg.sv
// types shared by the converter select block
package acs_pkg;

  typedef enum logic [1:0] {
    ACS_REF_EXT_PIN,
    ACS_REF_ANALOG_SUPPLY,
    ACS_REF_INT_1V1,
    ACS_REF_INT_2V56
  } acs_ref_t;

  typedef enum logic [1:0] {
    ACS_GAIN_1X,
    ACS_GAIN_10X,
    ACS_GAIN_200X
  } acs_gain_t;

  typedef enum logic {
    ACS_CONV_IDLE,
    ACS_CONV_BUSY
  } acs_conv_state_t;

endpackage : acs_pkg

// >>> core/acs_top.sv
// input select, result format and apb register file of the converter
// Behaviour
// R1 - result bytes hold value once done flag set
// R2 - single-ended code is unsigned vin*1024/vref
// R3 - single-ended spans 0x000 to 0x3FF
// R4 - differential code is diff*gain*512/vref
// R5 - differential codes are 10-bit two's complement
// R6 - top result bit gives differential sign
// R7 - differential saturates at 0x1FF and 0x200
// R8 - select register: ref, align, channel; reset zero
// R9 - reference select encodes four reference sources
// R10 - ref/channel changes wait for conversion end
// R11 - software avoids internal reference with external
// R12 - differential uses only 2.56V internal reference; the ref field passes to o_ref_sel unchecked for differential codes
// R13 - align bit picks left or right justify
// R14 - align change reformats result bytes at once
// R15 - codes pick single inputs, bandgap, ground
// R16 - codes pick differential pairs and gains
// R17 - done flag rises when result bytes update
// R18 - low read locks result until high read
// R19 - byte placement of left and right results
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "acs_cfg.svh"

module acs_top (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [`ACS_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // analog front end
  input wire logic i_sar_done_tgl,
  input wire logic [`ACS_RAW_W-1:0] i_sar_raw,
  output logic o_conv_start,
  output logic o_busy,
  output acs_pkg::acs_ref_t o_ref_sel,
  output logic o_diff,
  output logic [2:0] o_pos_input,
  output logic [2:0] o_neg_input,
  output acs_pkg::acs_gain_t o_gain,
  output logic o_bandgap,
  output logic o_ground,
  // interrupt
  output logic o_irq
);
  import acs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic sync_tgl_a_reg;
  logic sync_tgl_b_reg;
  logic tgl_prev_reg;
  logic [`ACS_RAW_W-1:0] sync_raw_a_reg;
  logic [`ACS_RAW_W-1:0] sync_raw_b_reg;
  logic done_evt;

  logic [7:0] sel_reg;
  logic [7:0] sel_next;
  logic [`ACS_RES_W-1:0] result_reg;
  logic [`ACS_RES_W-1:0] result_next;
  logic lock_reg;
  logic lock_next;
  logic [`ACS_IRQ_W-1:0] stat_reg;
  logic [`ACS_IRQ_W-1:0] stat_next;
  logic [`ACS_IRQ_W-1:0] mask_reg;
  logic [`ACS_IRQ_W-1:0] mask_next;
  logic irq_reg;
  logic irq_next;

  acs_conv_state_t state_reg;
  acs_conv_state_t state_next;
  logic start_reg;
  logic start_next;
  logic [1:0] act_ref_reg;
  logic [1:0] act_ref_next;
  logic [4:0] act_code_reg;
  logic [4:0] act_code_next;

  logic dec_diff;
  logic [2:0] dec_pos;
  logic [2:0] dec_neg;
  acs_gain_t dec_gain;
  logic dec_bandgap;
  logic dec_ground;
  logic diff_reg;
  logic [2:0] pos_reg;
  logic [2:0] neg_reg;
  acs_gain_t gain_reg;
  logic bandgap_reg;
  logic ground_reg;

  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] rd_data;
  logic addr_hit;
  logic xfer_end;
  logic wr_en;
  logic rd_low;
  logic rd_high;
  logic [7:0] fmt_low;
  logic [7:0] fmt_high;
  logic [`ACS_RES_W-1:0] sat_code;

  ////////////////////////////////////////////////////////////////////////////
  // front end crossing; raw code is stable before the toggle moves
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_tgl_a_reg <= 1'b0;
      sync_tgl_b_reg <= 1'b0;
      tgl_prev_reg <= 1'b0;
      sync_raw_a_reg <= '0;
      sync_raw_b_reg <= '0;
    end else begin
      sync_tgl_a_reg <= i_sar_done_tgl;
      sync_tgl_b_reg <= sync_tgl_a_reg;
      tgl_prev_reg <= sync_tgl_b_reg;
      sync_raw_a_reg <= i_sar_raw;
      sync_raw_b_reg <= sync_raw_a_reg;
    end
  end

  assign done_evt = sync_tgl_b_reg ^ tgl_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // result coding from the wide raw value
  always_comb begin
    if (diff_reg) begin
      // raw is signed here; clamp into the 10-bit two's complement range
      if (!sync_raw_b_reg[10] && sync_raw_b_reg[9]) begin
        sat_code = `ACS_DIFF_POS_MAX; // R7
      end else if (sync_raw_b_reg[10] && !sync_raw_b_reg[9]) begin
        sat_code = `ACS_DIFF_NEG_MIN; // R7
      end else begin
        sat_code = sync_raw_b_reg[9:0]; // R4 R5 R6
      end
    end else begin
      // unsigned, anything past full scale reads as the top code
      sat_code = sync_raw_b_reg[10] ? `ACS_SE_MAX : sync_raw_b_reg[9:0]; // R2 R3
    end
  end

  // formatting follows the live align bit, not the one at conversion
  always_comb begin
    if (sel_reg[`ACS_SEL_ALIGN]) begin
      fmt_high = result_reg[9:2]; // R13 R14 R19
      fmt_low = {result_reg[1:0], 6'h00}; // R19
    end else begin
      fmt_high = {6'h00, result_reg[9:8]}; // R13 R14 R19
      fmt_low = result_reg[7:0]; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode; one wait state so read data comes from a flop
  always_comb begin
    addr_hit = 1'b1;
    rd_data = 32'h0000_0000;
    case (i_paddr)
      `ACS_ADDR_SEL: rd_data = {24'h00_0000, sel_reg};
      `ACS_ADDR_RES_LOW: rd_data = {24'h00_0000, fmt_low}; // R1
      `ACS_ADDR_RES_HIGH: rd_data = {24'h00_0000, fmt_high}; // R1
      `ACS_ADDR_CTRL: rd_data = {31'h0000_0000, state_reg == ACS_CONV_BUSY};
      `ACS_ADDR_IRQ_STAT: rd_data = {30'h0000_0000, stat_reg};
      `ACS_ADDR_IRQ_MASK: rd_data = {30'h0000_0000, mask_reg};
      default: addr_hit = 1'b0;
    endcase
  end

  assign xfer_end = i_psel & i_penable & pready_reg;
  assign wr_en = xfer_end & i_pwrite & addr_hit & i_pstrb[0];
  assign rd_low = xfer_end & !i_pwrite & (i_paddr == `ACS_ADDR_RES_LOW);
  assign rd_high = xfer_end & !i_pwrite & (i_paddr == `ACS_ADDR_RES_HIGH);

  always_comb begin
    pready_next = i_psel & i_penable & !pready_reg;
    pslverr_next = i_psel & i_penable & !pready_reg & !addr_hit;
    prdata_next = prdata_reg;
    if (i_psel && i_penable && !pready_reg) begin
      prdata_next = i_pwrite ? 32'h0000_0000 : rd_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, conversion sequence and interrupt
  always_comb begin
    sel_next = sel_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    result_next = result_reg;
    lock_next = lock_reg;
    state_next = state_reg;
    start_next = 1'b0;
    if (wr_en && i_paddr == `ACS_ADDR_SEL) begin
      sel_next = i_pwdata[7:0]; // R8
    end
    if (wr_en && i_paddr == `ACS_ADDR_IRQ_MASK) begin
      mask_next = i_pwdata[`ACS_IRQ_W-1:0];
    end
    if (wr_en && i_paddr == `ACS_ADDR_IRQ_STAT) begin
      stat_next = stat_reg & ~i_pwdata[`ACS_IRQ_W-1:0];
    end
    // a high byte read releases before a low byte read can lock again
    if (rd_high) begin
      lock_next = 1'b0; // R18
    end
    if (rd_low) begin
      lock_next = 1'b1; // R18
    end
    case (state_reg)
      ACS_CONV_IDLE: begin
        if (wr_en && i_paddr == `ACS_ADDR_CTRL && i_pwdata[`ACS_CTRL_START]) begin
          state_next = ACS_CONV_BUSY;
          start_next = 1'b1;
        end
      end
      ACS_CONV_BUSY: begin
        if (done_evt) begin
          state_next = ACS_CONV_IDLE;
          if (lock_reg) begin
            // result dropped while software sits between the two byte reads
            stat_next[`ACS_IRQ_OVERRUN] = 1'b1; // R18
          end else begin
            result_next = sat_code; // R1
            stat_next[`ACS_IRQ_DONE] = 1'b1; // R17
          end
        end
      end
      default: state_next = ACS_CONV_IDLE;
    endcase
    irq_next = |(stat_next & mask_next);
  end

  // selection seen by the front end freezes during a conversion
  always_comb begin
    if (state_reg == ACS_CONV_BUSY && !done_evt) begin
      act_ref_next = act_ref_reg; // R10
      act_code_next = act_code_reg; // R10
    end else begin
      act_ref_next = sel_next[`ACS_SEL_REF_HI:`ACS_SEL_REF_LO]; // R9 R10
      act_code_next = sel_next[`ACS_SEL_CODE_HI:`ACS_SEL_CODE_LO]; // R10
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sel_reg <= `ACS_SEL_RESET;
      mask_reg <= `ACS_IRQ_RESET;
      stat_reg <= `ACS_IRQ_RESET;
      result_reg <= `ACS_RES_RESET;
      lock_reg <= 1'b0;
      state_reg <= ACS_CONV_IDLE;
      start_reg <= 1'b0;
      irq_reg <= 1'b0;
      act_ref_reg <= 2'h0;
      act_code_reg <= 5'h00;
    end else begin
      sel_reg <= sel_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      result_reg <= result_next;
      lock_reg <= lock_next;
      state_reg <= state_next;
      start_reg <= start_next;
      irq_reg <= irq_next;
      act_ref_reg <= act_ref_next;
      act_code_reg <= act_code_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel decode, registered so the pins come from flops
  acs_chan_decode u_decode (
    .i_code(act_code_next),
    .o_diff(dec_diff),
    .o_pos_input(dec_pos),
    .o_neg_input(dec_neg),
    .o_gain(dec_gain),
    .o_bandgap(dec_bandgap),
    .o_ground(dec_ground)
  );

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      diff_reg <= 1'b0;
      pos_reg <= 3'h0;
      neg_reg <= 3'h0;
      gain_reg <= ACS_GAIN_1X;
      bandgap_reg <= 1'b0;
      ground_reg <= 1'b0;
    end else begin
      diff_reg <= dec_diff; // R15 R16
      pos_reg <= dec_pos;
      neg_reg <= dec_neg;
      gain_reg <= dec_gain;
      bandgap_reg <= dec_bandgap;
      ground_reg <= dec_ground;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_conv_start = start_reg;
  assign o_busy = state_reg == ACS_CONV_BUSY;
  assign o_ref_sel = acs_ref_t'(act_ref_reg); // R9
  assign o_diff = diff_reg;
  assign o_pos_input = pos_reg;
  assign o_neg_input = neg_reg;
  assign o_gain = gain_reg;
  assign o_bandgap = bandgap_reg;
  assign o_ground = ground_reg;
  assign o_irq = irq_reg;

endmodule : acs_top

// >>> dv/acs_fe_model.sv
// front end stand-in: answers each start with a raw code after a delay
`timescale 1ns/1ps
module acs_fe_model (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_start,
  input wire logic [10:0] i_code,
  input wire logic [7:0] i_delay,
  output logic o_done_tgl,
  output logic [10:0] o_raw
);
  logic [8:0] cnt;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 9'h000;
      o_done_tgl <= 1'b0;
      o_raw <= 11'h000;
    end else if (i_start) begin
      cnt <= {1'b0, i_delay} + 9'h001;
      o_raw <= i_code;
    end else if (cnt == 9'h001) begin
      cnt <= 9'h000;
      // raw already stable, so the toggle never races the code
      o_done_tgl <= ~o_done_tgl;
    end else if (cnt != 9'h000) begin
      cnt <= cnt - 9'h001;
    end
  end
endmodule : acs_fe_model

// >>> dv/acs_sva.sv
// port checks for the converter select block
`timescale 1ns/1ps
module acs_sva (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_conv_start,
  input wire logic o_busy,
  input wire acs_pkg::acs_ref_t o_ref_sel,
  input wire logic o_diff,
  input wire logic [2:0] o_pos_input,
  input wire logic [2:0] o_neg_input,
  input wire acs_pkg::acs_gain_t o_gain,
  input wire logic o_bandgap,
  input wire logic o_ground,
  input wire logic o_irq
);
  import acs_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////////////
  chk_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready held too long");
  chk_ready_time: assert property ($rose(i_penable) && i_psel |=> o_pready) else $error("ready late");
  chk_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
  chk_err_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0) else $error("error read not zero");
  chk_start_idle: assert property (o_conv_start |-> o_busy && !$past(o_busy))
    else $error("start while busy");
  // selection must not move under a running conversion
  chk_sel_frozen: assert property (o_busy && $past(o_busy) |-> $stable(o_ref_sel) && $stable(o_diff)
    && $stable(o_pos_input) && $stable(o_neg_input)) else $error("selection moved while busy");
  chk_single_neg: assert property (!o_diff && !o_bandgap && !o_ground |-> o_neg_input == 3'h0)
    else $error("single input with negative leg");
  chk_diff_legs: assert property (o_diff |-> o_neg_input inside {3'h0, 3'h1, 3'h2} && o_gain != 2'h3)
    else $error("bad differential leg");
  chk_source_excl: assert property (o_bandgap |-> !o_ground && !o_diff)
    else $error("bandgap with other source");
  cover property (o_conv_start);
  cover property ($fell(o_busy));
  cover property (o_pslverr);
  cover property (o_irq && o_diff);
endmodule : acs_sva
bind acs_top acs_sva u_sva (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_conv_start(o_conv_start), .o_busy(o_busy), .o_ref_sel(o_ref_sel), .o_diff(o_diff),
  .o_pos_input(o_pos_input), .o_neg_input(o_neg_input), .o_gain(o_gain), .o_bandgap(o_bandgap),
  .o_ground(o_ground), .o_irq(o_irq));

// >>> dv/tb.sv
// self-checking bench for the converter select block
`timescale 1ns/1ps
`include "acs_cfg.svh"
module tb;
  import acs_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, tgl, start, busy, diff, bg, gnd, irq, e;
  logic [10:0] raw;
  logic [10:0] fe_code = 11'h000;
  logic [7:0] fe_delay = 8'h04;
  acs_ref_t ref_sel;
  acs_gain_t gain;
  logic [2:0] pos, neg, px, nx;
  logic [1:0] gx;
  logic [1:0] rx;
  logic [4:0] c;
  logic [31:0] q;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] t_sel [8] = '{8'h00, 8'h47, 8'h5E, 8'hD0, 8'hCD, 8'hD8, 8'hDA, 8'hC9};
  logic [10:0] t_raw [8] = '{11'h000, 11'h3FF, 11'h500, 11'h1FF, 11'h670, 11'h400, 11'h7FF, 11'h300};
  logic [9:0] t_res [8] = '{10'h000, 10'h3FF, 10'h3FF, 10'h1FF, 10'h270, 10'h200, 10'h3FF, 10'h1FF};
  always #2 mclk = ~mclk;
  acs_top u_dut (.i_mclk(mclk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sar_done_tgl(tgl), .i_sar_raw(raw), .o_conv_start(start), .o_busy(busy),
    .o_ref_sel(ref_sel), .o_diff(diff), .o_pos_input(pos), .o_neg_input(neg), .o_gain(gain),
    .o_bandgap(bg), .o_ground(gnd), .o_irq(irq));
  acs_fe_model u_fe (.i_mclk(mclk), .i_arst_n(arst_n), .i_start(start), .i_code(fe_code),
    .i_delay(fe_delay), .o_done_tgl(tgl), .o_raw(raw));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk iff pready === 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic conv(input logic [7:0] s, input logic [10:0] r, input logic [9:0] x);
    fe_code <= r;
    apb(1'b1, `ACS_ADDR_SEL, {24'h0, s});
    apb(1'b1, `ACS_ADDR_CTRL, 32'h1);
    @(posedge mclk iff busy === 1'b0);
    chk(irq, 1'b1);
    apb(1'b0, `ACS_ADDR_RES_LOW, 32'h0);
    chk(q, x[7:0]);
    apb(1'b0, `ACS_ADDR_RES_HIGH, 32'h0);
    chk(q, x[9:8]);
    apb(1'b1, `ACS_ADDR_SEL, {24'h0, s | 8'h20});
    apb(1'b0, `ACS_ADDR_RES_LOW, 32'h0);
    chk(q, {x[1:0], 6'h0});
    apb(1'b0, `ACS_ADDR_RES_HIGH, 32'h0);
    chk(q, x[9:2]);
    apb(1'b0, `ACS_ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, `ACS_ADDR_IRQ_STAT, 32'h1);
    @(posedge mclk);
    chk(irq, 1'b0);
  endtask : conv
  task automatic end_of_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, `ACS_ADDR_SEL, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, `ACS_ADDR_SEL, 32'hED);
    apb(1'b0, `ACS_ADDR_SEL, 32'h0);
    chk(q, 32'hED);
    pstrb <= 4'h0;
    apb(1'b1, `ACS_ADDR_SEL, 32'hFF);
    pstrb <= 4'hF;
    apb(1'b0, `ACS_ADDR_SEL, 32'h0);
    chk(q, 32'hED);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, `ACS_ADDR_IRQ_MASK, 32'h1);
    $display("test register access done");
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      px = (c[3] && !c[4]) ? {1'b0, c[2], c[0]} : c[2:0];
      nx = (c[3] && !c[4]) ? {1'b0, c[2], 1'b0} : (c[4] ? (c[3] ? 3'h2 : 3'h1) : 3'h0);
      gx = (c[3] && !c[4]) ? (c[1] ? 2'h2 : 2'h1) : 2'h0;
      // nothing drives the reference pin; pairs stay on the 2.56V reference
      rx = (c >= 5'h08 && c < 5'h1E) ? 2'h3 : c[1:0];
      apb(1'b1, `ACS_ADDR_SEL, {24'h0, rx, 1'b0, c});
      @(posedge mclk);
      chk(ref_sel, rx);
      chk({diff, bg, gnd}, {c >= 5'h08 && c < 5'h1E, c == 5'h1E, c == 5'h1F});
      if (c < 5'h1E) chk({pos, neg}, {px, nx});
      if (diff === 1'b1) chk(gain, gx);
    end
    $display("test selection decode done");
    for (int i = 0; i < 8; i++) conv(t_sel[i], t_raw[i], t_res[i]);
    $display("test result coding done");
    fe_delay <= 8'd40;
    fe_code <= 11'h123;
    apb(1'b1, `ACS_ADDR_SEL, 32'h07);
    @(posedge mclk);
    apb(1'b1, `ACS_ADDR_CTRL, 32'h1);
    apb(1'b1, `ACS_ADDR_SEL, 32'hF0);
    // start while busy is ignored; a second start pulse trips the checker
    apb(1'b1, `ACS_ADDR_CTRL, 32'h1);
    chk({ref_sel, diff, pos}, {2'h0, 1'b0, 3'h7});
    apb(1'b0, `ACS_ADDR_RES_HIGH, 32'h0);
    chk(q, 32'h7F);
    apb(1'b0, `ACS_ADDR_CTRL, 32'h0);
    chk(q, 32'h1);
    @(posedge mclk iff busy === 1'b0);
    @(posedge mclk);
    chk({ref_sel, diff, pos, neg}, {2'h3, 1'b1, 3'h0, 3'h1});
    $display("test held selection done");
    apb(1'b1, `ACS_ADDR_IRQ_STAT, 32'h3);
    apb(1'b0, `ACS_ADDR_RES_LOW, 32'h0);
    chk(q, 32'hC0);
    fe_code <= 11'h055;
    apb(1'b1, `ACS_ADDR_CTRL, 32'h1);
    @(posedge mclk iff busy === 1'b0);
    apb(1'b0, `ACS_ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h2);
    chk(irq, 1'b0);
    apb(1'b0, `ACS_ADDR_RES_HIGH, 32'h0);
    chk(q, 32'h48);
    apb(1'b1, `ACS_ADDR_IRQ_MASK, 32'h3);
    @(posedge mclk);
    chk(irq, 1'b1);
    apb(1'b1, `ACS_ADDR_IRQ_STAT, 32'h3);
    @(posedge mclk);
    chk(irq, 1'b0);
    $display("test result lock done");
    end_of_test();
  end
endmodule : tb
